/* File: hw/dsac_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Controller: AXI4-Lite slave registers drive the converter link
module dsac_host (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Converter link
    dsac_if.host             link
);
    typedef enum logic [2:0] {
        DSAC_H_IDLE, DSAC_H_LOW, DSAC_H_BUSY, DSAC_H_RD, DSAC_H_GAP
    } dsac_host_state_t;

    dsac_host_state_t state;
    logic             aw_got;
    logic             w_got;
    logic [3:0]       aw_addr;
    logic [31:0]      w_data;
    logic             pair;
    logic             sleep_mode;
    logic             go;
    logic             done;
    logic [1:0]       rd_idx;
    logic [7:0]       cnt;
    logic [11:0]      res1;
    logic [11:0]      res2;

    // Write channel: address and data in either order
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dsac_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (aw_got && w_got) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == dsac_pkg::REG_CTRL)
                               ? dsac_pkg::RESP_OKAY
                               : dsac_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire ctrl_wr = aw_got && w_got && aw_addr == dsac_pkg::REG_CTRL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair <= 1'b0;
            sleep_mode <= 1'b0;
            go <= 1'b0;
        end else begin
            if (ctrl_wr && state == DSAC_H_IDLE) begin
                pair <= w_data[dsac_pkg::CTRL_PAIR_BIT];
                sleep_mode <= w_data[dsac_pkg::CTRL_SLEEP_BIT];
            end
            if (ctrl_wr && w_data[dsac_pkg::CTRL_START_BIT]) begin
                go <= 1'b1;
            end else if (state == DSAC_H_LOW) begin
                go <= 1'b0;
            end
        end
    end

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= dsac_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= dsac_pkg::RESP_OKAY;
            case (s_axi_araddr)
                dsac_pkg::REG_CTRL:   s_axi_rdata <= {29'h0, sleep_mode,
                                                      pair, go};
                dsac_pkg::REG_STATUS: s_axi_rdata <= {29'h0, link.busy,
                                                      state != DSAC_H_IDLE,
                                                      done};
                dsac_pkg::REG_RES1:   s_axi_rdata <= {20'h0, res1};
                dsac_pkg::REG_RES2:   s_axi_rdata <= {20'h0, res2};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= dsac_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Link sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= DSAC_H_IDLE;
            cnt <= '0;
            rd_idx <= '0;
            done <= 1'b0;
            res1 <= '0;
            res2 <= '0;
            link.conversion_start_n <= 1'b1;
            link.pair_select <= 1'b0;
            link.cs_n <= 1'b1;
            link.rd_n <= 1'b1;
        end else begin
            case (state)
                DSAC_H_IDLE: begin
                    // Select moves only while start is high, then settles
                    if (link.pair_select != pair) begin
                        link.pair_select <= pair;
                        cnt <= '0;
                    end else if (cnt < 8'(dsac_pkg::SEL_SETUP_CYCLES)) begin
                        cnt <= cnt + 8'h01;
                    end else if (go) begin
                        link.conversion_start_n <= 1'b0;
                        done <= 1'b0;
                        state <= DSAC_H_LOW;
                    end
                end
                DSAC_H_LOW: begin
                    // Start stays low until hold is seen, covering wake-up
                    if (link.busy) begin
                        if (!sleep_mode) begin
                            link.conversion_start_n <= 1'b1;
                        end
                        state <= DSAC_H_BUSY;
                    end
                end
                DSAC_H_BUSY: begin
                    // No reads while converting
                    if (!link.busy) begin
                        link.cs_n <= 1'b0;
                        rd_idx <= '0;
                        cnt <= '0;
                        state <= DSAC_H_RD;
                    end
                end
                DSAC_H_RD: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'h00) begin
                        link.rd_n <= 1'b0;
                        link.cs_n <= 1'b0;
                    end
                    if (cnt == 8'(dsac_pkg::STROBE_CYCLES)) begin
                        link.rd_n <= 1'b1;
                        if (rd_idx == 2'd0) res1 <= link.data;
                        else res2 <= link.data;
                    end
                    if (cnt == 8'(dsac_pkg::STROBE_CYCLES + 1)) begin
                        cnt <= '0;
                        rd_idx <= rd_idx + 2'd1;
                        // Sleep mode closes the select after each strobe
                        if (rd_idx == 2'd1 || sleep_mode) begin
                            link.cs_n <= 1'b1;
                        end
                        if (rd_idx == 2'd1) state <= DSAC_H_GAP;
                    end
                end
                DSAC_H_GAP: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(dsac_pkg::SEL_SETUP_CYCLES)) begin
                        link.conversion_start_n <= 1'b1;
                        done <= 1'b1;
                        state <= DSAC_H_IDLE;
                    end
                end
                default: state <= DSAC_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: hw/dsac_pkg.sv */
package dsac_pkg;
    // Converter timing
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int CONV_TIME_NS       = 3600;
    localparam int CONV_CYCLES        = CONV_TIME_NS * 1000 / CLK_PERIOD_PS;
    localparam int WAKE_EXT_NS        = 2500;
    localparam int WAKE_EXT_CYCLES    = WAKE_EXT_NS * 1000 / CLK_PERIOD_PS;
    localparam int WAKE_INT_MS        = 5;
    localparam int WAKE_INT_CYCLES    = WAKE_INT_MS * 1000000 / 5;
    localparam int INT_CLK_MAX_KHZ    = 3700;
    localparam int INT_CLK_DIV        = (1000000000 / CLK_PERIOD_PS
                                         + INT_CLK_MAX_KHZ - 1)
                                        / INT_CLK_MAX_KHZ;
    // Host timing
    localparam int SEL_SETUP_NS       = 400;
    localparam int SEL_SETUP_CYCLES   = (SEL_SETUP_NS * 1000
                                         + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_GAP_NS        = 300;
    localparam int READ_GAP_CYCLES    = (READ_GAP_NS * 1000
                                         + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_TIME_NS       = 100;
    localparam int STROBE_CYCLES      = 2;
    localparam int CYCLE_TIME_NS      = 4000;
    localparam int CYCLE_CYCLES       = CYCLE_TIME_NS * 1000 / CLK_PERIOD_PS;
    localparam int DATA_W             = 12;
    // Host register map (AXI4-Lite byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RES1   = 4'h8;
    localparam logic [3:0] REG_RES2   = 4'hc;
    localparam int CTRL_START_BIT     = 0;
    localparam int CTRL_PAIR_BIT      = 1;
    localparam int CTRL_SLEEP_BIT     = 2;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/dsac_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dsac_if;
    logic        conversion_start_n;
    logic        pair_select;
    logic        cs_n;
    logic        rd_n;
    logic        busy;
    logic [11:0] data;
    modport device (
        input  conversion_start_n, pair_select, cs_n, rd_n,
        output busy, data
    );
    modport host (
        output conversion_start_n, pair_select, cs_n, rd_n,
        input  busy, data
    );
endinterface
`default_nettype wire

/* File: hw/dsac_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Down counter: load, then done pulses when count reaches one
module dsac_timer #(
    parameter int W = 20
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              running,
    output logic              done
);
    logic [W-1:0] remain;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - W'(1);
        end
    end

    assign running = (remain != '0);
    assign done    = (remain == W'(1)) && !load;
endmodule
`default_nettype wire

/* File: hw/dsac_device.sv */
`timescale 1ns/1ps
`default_nettype none
module dsac_device #(
    parameter int DATA_W      = dsac_pkg::DATA_W,
    parameter bit BIPOLAR     = 1'b1,
    parameter bit INT_REF     = 1'b0,
    parameter int WAKE_INT    = dsac_pkg::WAKE_INT_CYCLES
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Converter link
    dsac_if.device                 link,
    // Sampled analog inputs, offset binary from the front end
    input  wire logic [DATA_W-1:0] pair_a_input_1,
    input  wire logic [DATA_W-1:0] pair_a_input_2,
    input  wire logic [DATA_W-1:0] pair_b_input_1,
    input  wire logic [DATA_W-1:0] pair_b_input_2,
    // Status
    output logic                   asleep
);
    localparam int TW = 22;
    typedef enum logic [2:0] {
        DSAC_IDLE, DSAC_CONV, DSAC_SLEEP, DSAC_WAKE, DSAC_WAIT_FALL
    } dsac_state_t;

    dsac_state_t       state;
    logic              start_q;
    logic              rd_q;
    logic              start_fall;
    logic              start_rise;
    logic              rd_rise;
    logic [TW-1:0]     tick_div;
    logic              tick;
    logic [7:0]        tick_cnt;
    logic              conv_done;
    logic              wake_load;
    logic              wake_done;
    logic              pair_q;
    logic [DATA_W-1:0] hold1;
    logic [DATA_W-1:0] hold2;
    logic [DATA_W-1:0] res1;
    logic [DATA_W-1:0] res2;
    logic              read_ptr;
    logic              next_hold;

    assign start_fall = start_q && !link.conversion_start_n;
    assign start_rise = !start_q && link.conversion_start_n;
    assign rd_rise    = !rd_q && link.rd_n && !link.cs_n;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b1;
            rd_q    <= 1'b1;
        end else begin
            start_q <= link.conversion_start_n;
            rd_q    <= link.rd_n | link.cs_n;
        end
    end

    // Internal conversion tick, never leaves the block
    always_ff @(posedge aclk) begin
        if (!aresetn || next_hold) begin
            tick_div <= '0;
        end else if (tick) begin
            tick_div <= '0;
        end else begin
            tick_div <= tick_div + TW'(1);
        end
    end
    assign tick = (tick_div == TW'(dsac_pkg::INT_CLK_DIV - 1));

    // Ticks per conversion at the internal rate, rounded down
    localparam int CONV_TICKS = dsac_pkg::CONV_CYCLES
                                / dsac_pkg::INT_CLK_DIV;
    always_ff @(posedge aclk) begin
        if (!aresetn || next_hold) begin
            tick_cnt <= '0;
        end else if (state == DSAC_CONV && tick) begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end
    assign conv_done = (state == DSAC_CONV)
                       && (tick_cnt == 8'(CONV_TICKS));

    // Hold instant: falling start when awake, or end of wake
    always_comb begin
        next_hold = 1'b0;
        case (state)
            DSAC_IDLE:      next_hold = start_fall;
            DSAC_WAKE:      next_hold = wake_done
                                        && !link.conversion_start_n;
            DSAC_WAIT_FALL: next_hold = start_fall;
            default:        next_hold = 1'b0;
        endcase
    end

    assign wake_load = (state == DSAC_SLEEP) && start_rise;

    dsac_timer #(
        .W (TW)
    ) u_wake (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (wake_load),
        .count   (INT_REF ? TW'(WAKE_INT)
                          : TW'(dsac_pkg::WAKE_EXT_CYCLES)),
        .running (),
        .done    (wake_done)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= DSAC_IDLE;
        end else begin
            case (state)
                DSAC_IDLE: begin
                    if (next_hold) state <= DSAC_CONV;
                end
                DSAC_CONV: begin
                    if (conv_done) begin
                        if (!link.conversion_start_n) begin
                            state <= DSAC_SLEEP;
                        end else begin
                            state <= DSAC_IDLE;
                        end
                    end
                end
                DSAC_SLEEP: begin
                    if (wake_load) state <= DSAC_WAKE;
                end
                DSAC_WAKE: begin
                    if (next_hold) begin
                        state <= DSAC_CONV;
                    end else if (wake_done) begin
                        state <= DSAC_WAIT_FALL;
                    end
                end
                DSAC_WAIT_FALL: begin
                    if (next_hold) state <= DSAC_CONV;
                end
                default: state <= DSAC_IDLE;
            endcase
        end
    end

    // Track/hold: both inputs of the selected pair caught together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_q <= 1'b0;
            hold1  <= '0;
            hold2  <= '0;
        end else if (next_hold) begin
            pair_q <= link.pair_select;
            hold1  <= link.pair_select ? pair_b_input_1
                                       : pair_a_input_1;
            hold2  <= link.pair_select ? pair_b_input_2
                                       : pair_a_input_2;
        end
    end

    // Output latch loads only at end of conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res1 <= '0;
            res2 <= '0;
        end else if (conv_done) begin
            res1 <= BIPOLAR ? {~hold1[DATA_W-1], hold1[DATA_W-2:0]}
                            : hold1;
            res2 <= BIPOLAR ? {~hold2[DATA_W-1], hold2[DATA_W-2:0]}
                            : hold2;
        end
    end

    // Read pointer advances at the end of each strobe
    always_ff @(posedge aclk) begin
        if (!aresetn || next_hold) begin
            read_ptr <= 1'b0;
        end else if (rd_rise) begin
            read_ptr <= ~read_ptr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.data <= '0;
        end else begin
            link.data <= read_ptr ? res2 : res1;
        end
    end

    assign link.busy = (state == DSAC_CONV);
    assign asleep    = (state == DSAC_SLEEP);
endmodule
`default_nettype wire

/* File: bench/dsac_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dsac_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Link
    input wire logic        conversion_start_n,
    input wire logic        pair_select,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        busy,
    input wire logic [11:0] data,
    // Device status
    input wire logic        asleep
);
    localparam int CONV_MAX = 720;
    localparam int CONV_MIN = 702;
    localparam int WAKE_MIN = 495;
    localparam int WAKE_MAX = 510;
    logic [9:0]  bcnt;
    logic [11:0] wcnt;
    logic [7:0]  scnt;
    logic [7:0]  gcnt;
    logic [7:0]  rcnt;
    logic        slept;
    logic        waking;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Busy length, select age and read gap
    always_ff @(posedge aclk) begin
        bcnt <= (!aresetn || !busy) ? '0 : bcnt + 10'd1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scnt <= '1;
            gcnt <= '1;
            rcnt <= '0;
        end else begin
            scnt <= $changed(pair_select) ? '0 : scnt + {7'd0, scnt != '1};
            gcnt <= !cs_n ? '0 : gcnt + {7'd0, gcnt != '1};
            rcnt <= cs_n ? '0 : rcnt + {7'd0, rcnt != '1};
        end
    end
    // Sleep and wake tracking
    always_ff @(posedge aclk) begin
        if (!aresetn || $rose(conversion_start_n)) begin
            slept <= 1'b0;
        end else if ($fell(busy) && !conversion_start_n) begin
            slept <= 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || busy) begin
            waking <= 1'b0;
        end else if (slept && $rose(conversion_start_n)) begin
            waking <= 1'b1;
        end
        wcnt <= !waking ? '0 : wcnt + {11'd0, wcnt != '1};
    end
    sequence s_fall_awake;
        $fell(conversion_start_n) && !busy && (!waking || wcnt > WAKE_MAX);
    endsequence
    sequence s_late_wake;
        waking && wcnt == WAKE_MAX && !conversion_start_n;
    endsequence
    chk_fall_busy: assert property (s_fall_awake |=> busy)
        else $error("busy missing after start fall");
    chk_busy_cause: assert property (
        $rose(busy) |-> !$past(conversion_start_n))
        else $error("busy rose without start low");
    chk_conv_max: assert property (busy |-> bcnt < CONV_MAX)
        else $error("conversion too long");
    chk_conv_min: assert property ($fell(busy) |-> bcnt >= CONV_MIN)
        else $error("conversion faster than internal clock");
    chk_data_held: assert property (
        busy && $past(busy, 3) |-> $stable(data))
        else $error("output changed during conversion");
    chk_auto_sleep: assert property (
        $fell(busy) && !conversion_start_n |-> ##[0:1] asleep)
        else $error("no sleep with start low");
    chk_stay_awake: assert property (
        $fell(busy) && conversion_start_n |-> !asleep [*2])
        else $error("slept with start high");
    chk_wake_delay: assert property (
        $rose(busy) && waking |-> wcnt >= WAKE_MIN)
        else $error("hold before wake time");
    chk_wake_hold: assert property (s_late_wake |-> ##[1:2] busy)
        else $error("no hold after wake");
    chk_no_read_busy: assert property (busy |-> cs_n)
        else $error("read during conversion");
    chk_sel_setup: assert property (
        $fell(conversion_start_n) |-> !$changed(pair_select) && scnt >= 79)
        else $error("select changed too close to start");
    chk_read_gap: assert property (
        $fell(conversion_start_n) |-> gcnt >= 60)
        else $error("read too close to start");
    chk_read_time: assert property (!cs_n |-> rcnt < 20)
        else $error("read of both results too long");
endmodule
`default_nettype wire

/* File: bench/dual_sar_adc_conversion_read_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_sar_adc_conversion_read_control_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = '0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [3:0]  araddr = '0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [11:0] a1 = '0;
    logic [11:0] a2 = '0;
    logic [11:0] b1 = '0;
    logic [11:0] b2 = '0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic        asleep;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [1:0]  resp;
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    dsac_if lnk ();
    dsac_host dsac_host_i (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (awaddr),
        .s_axi_awvalid (awvalid),
        .s_axi_awready (awready),
        .s_axi_wdata   (wdata),
        .s_axi_wstrb   (4'hf),
        .s_axi_wvalid  (wvalid),
        .s_axi_wready  (wready),
        .s_axi_bresp   (bresp),
        .s_axi_bvalid  (bvalid),
        .s_axi_bready  (bready),
        .s_axi_araddr  (araddr),
        .s_axi_arvalid (arvalid),
        .s_axi_arready (arready),
        .s_axi_rdata   (rdata),
        .s_axi_rresp   (rresp),
        .s_axi_rvalid  (rvalid),
        .s_axi_rready  (rready),
        .link          (lnk)
    );
    dsac_device #(
        .WAKE_INT (50)
    ) dsac_device_i (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .link           (lnk),
        .pair_a_input_1 (a1),
        .pair_a_input_2 (a2),
        .pair_b_input_1 (b1),
        .pair_b_input_2 (b2),
        .asleep         (asleep)
    );
    dsac_asserts dsac_asserts_i (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .conversion_start_n (lnk.conversion_start_n),
        .pair_select        (lnk.pair_select),
        .cs_n               (lnk.cs_n),
        .rd_n               (lnk.rd_n),
        .busy               (lnk.busy),
        .data               (lnk.data),
        .asleep             (asleep)
    );
    always #2.5 aclk = ~aclk;
    task automatic wrap_up();
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk_idle();
        @(posedge aclk);
        chk("idle link", 32'h0001_c000, 32'({lnk.conversion_start_n,
            lnk.cs_n, lnk.rd_n, lnk.busy, asleep, lnk.data}));
    endtask
    task automatic convert(input logic pr, input logic slp,
                           input logic [11:0] v);
        logic [11:0] e1;
        logic [11:0] e2;
        e1 = (pr ? v + 12'h001 : v) ^ 12'h800;
        e2 = (pr ? v ^ 12'h5a5 : ~v) ^ 12'h800;
        a1 <= v;
        a2 <= ~v;
        b1 <= v + 12'h001;
        b2 <= v ^ 12'h5a5;
        axi_wr(dsac_pkg::REG_CTRL, {29'h0, slp, pr, 1'b1});
        chk("ctrl resp", 32'(dsac_pkg::RESP_OKAY), 32'(resp));
        while (lnk.busy !== 1'b1) @(posedge aclk);
        // Inputs move after hold; results must not follow
        a1 <= 12'h0f0;
        a2 <= 12'h0f0;
        b1 <= 12'h0f0;
        b2 <= 12'h0f0;
        while (lnk.busy !== 1'b0) @(posedge aclk);
        chk("asleep", 32'(slp), 32'(asleep));
        do axi_rd(dsac_pkg::REG_STATUS); while (rd[1] !== 1'b0);
        chk("status", 32'h0000_0001, 32'(rd[2:0]));
        axi_rd(dsac_pkg::REG_RES1);
        chk("first result", 32'(e1), 32'(rd[11:0]));
        axi_rd(dsac_pkg::REG_RES2);
        chk("second result", 32'(e2), 32'(rd[11:0]));
        chk("link data", 32'(e1), 32'(lnk.data));
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        chk_idle();
        for (int i = 1; i < 4; i++) begin
            axi_wr(4'(4 * i), 32'h0000_0001);
            chk("refused write", 32'(dsac_pkg::RESP_SLVERR), 32'(resp));
        end
        convert(1'b0, 1'b0, 12'h000);
        convert(1'b1, 1'b0, 12'hfff);
        convert(1'b1, 1'b1, 12'h7ff);
        convert(1'b0, 1'b1, 12'h800);
        convert(1'b0, 1'b0, 12'h123);
        // Reset in mid-conversion, then run again
        axi_wr(dsac_pkg::REG_CTRL, 32'h0000_0001);
        while (lnk.busy !== 1'b1) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        chk_idle();
        convert(1'b1, 1'b0, 12'h5a5);
        wrap_up();
    end
endmodule
`default_nettype wire
